//--- design/mppio_defs.vh
// Register offsets, reset values and field positions of the parallel I/O block.
// Assumes inclusion by bare name from the design file.
`ifndef MPPIO_DEFS_VH
`define MPPIO_DEFS_VH
// Register indices; byte address is four times the index.
`define MPPIO_IDX_F_DIR   7'h03
`define MPPIO_IDX_F_PINS  7'h05
`define MPPIO_IDX_C_DIR   7'h07
`define MPPIO_IDX_D_PINS  7'h08
`define MPPIO_IDX_D_DIR   7'h09
`define MPPIO_IDX_E_PINS  7'h0A
`define MPPIO_IDX_H_PINS  7'h7C
`define MPPIO_IDX_H_DIR   7'h7D
`define MPPIO_IDX_G_PINS  7'h7E
`define MPPIO_IDX_G_DIR   7'h7F
// Added control register holding the resistor enables.
`define MPPIO_IDX_PULL    7'h2C
// Reset value of every direction register.
`define MPPIO_DIR_RESET   8'h00
// Reset value of the pull control register.
`define MPPIO_PULL_RESET  3'h7
// Field positions in the pull control register.
`define MPPIO_PULL_F      0
`define MPPIO_PULL_G      1
`define MPPIO_PULL_H      2
// Width of group D.
`define MPPIO_D_WIDTH     6
// AHB transfer type NONSEQ bit.
`define MPPIO_HTRANS_ACT  1
`endif

//--- design/mppio_port.v
// Parallel I/O groups C, D, E, F, G and H with an AHB-Lite register slave.
// Assumes pin inputs synchronous to hclk, pads resolved outside from enables,
// and a mode input that is stable while the block runs.
//
// Behaviour
// - Direction bit one drives, zero receives
// - Direction registers clear to zero on reset
// - Group D has six bidirectional lines
// - Group D bits seven and six read zero
// - Group D shares serial one and SPI
// - Groups D, E, H reset as inputs
// - Data registers untouched by reset
// - Alternate function pins ignore data writes
// - Group E eight read-only input lines
// - Group E line n feeds analog channel n
// - Expanded mode drives address low byte on F
// - Expanded mode removes F registers from map
// - Single-chip F pins reset as pulled inputs
// - G line seven is read/write strobe expanded
// - G low lines reset as pulled inputs
// - Group H shares PWM and serial two, three
// - H pull-ups high nibble, pull-downs low
// - One enable switches all eight H resistors
`timescale 1ns/10ps
`default_nettype none
`include "mppio_defs.vh"

module mppio_port (
	input  wire        hclk,               // System clock, 20 MHz.
	input  wire        hresetn,            // Asynchronous active-low reset.
	input  wire        hsel,               // Slave select.
	input  wire [31:0] haddr,              // Byte address.
	input  wire [1:0]  htrans,             // Transfer type.
	input  wire        hwrite,             // Write when high.
	input  wire [2:0]  hsize,              // Transfer size.
	input  wire [31:0] hwdata,             // Write data.
	input  wire        hready,             // Bus ready in.
	output reg  [31:0] hrdata,             // Read data.
	output wire        hreadyout,          // Slave ready.
	output wire        hresp,              // Response, always OKAY.
	input  wire        expanded_mode,      // High in expanded or test mode.
	output wire [7:0]  group_c_dir_bit,    // Group C direction to the data bus logic.
	input  wire [5:0]  group_d_in,         // Group D pin levels.
	output wire [5:0]  group_d_out,        // Group D pin drive values.
	output wire [5:0]  group_d_oe,         // Group D output enables.
	input  wire [5:0]  group_d_alt_en,     // Group D alternate function owns the pin.
	input  wire [5:0]  group_d_alt_out,    // Group D alternate drive values.
	input  wire [5:0]  group_d_alt_oe,     // Group D alternate output enables.
	output wire        serial1_receive_in, // Serial one receive line.
	output wire        spi_miso_in,        // SPI data in.
	output wire        spi_mosi_in,        // SPI data out line sensed.
	output wire        spi_sck_in,         // SPI clock sensed.
	output wire        spi_ss_in,          // SPI select sensed.
	input  wire [7:0]  group_e_in,         // Group E pin levels.
	output wire [7:0]  analog_channel,     // Group E lines to the converter.
	input  wire [7:0]  group_f_in,         // Group F pin levels.
	output wire [7:0]  group_f_out,        // Group F pin drive values.
	output wire [7:0]  group_f_oe,         // Group F output enables.
	output wire [7:0]  group_f_pullup,     // Group F pull-up enables.
	input  wire [7:0]  ext_addr_low,       // External address bits 0 to 7.
	input  wire [7:0]  group_g_in,         // Group G pin levels.
	output wire [7:0]  group_g_out,        // Group G pin drive values.
	output wire [7:0]  group_g_oe,         // Group G output enables.
	output wire [6:0]  group_g_pullup,     // Group G low-line pull-ups.
	input  wire        ext_read_write,     // External read/write strobe.
	input  wire [7:0]  group_h_in,         // Group H pin levels.
	output wire [7:0]  group_h_out,        // Group H pin drive values.
	output wire [7:0]  group_h_oe,         // Group H output enables.
	output wire [3:0]  group_h_pullup,     // Pull-ups on lines 7 to 4.
	output wire [3:0]  group_h_pulldown,   // Pull-downs on lines 3 to 0.
	input  wire [7:0]  group_h_alt_en,     // Group H alternate function owns the pin.
	input  wire [7:0]  group_h_alt_out,    // Group H alternate drive values.
	input  wire [7:0]  group_h_alt_oe,     // Group H alternate output enables.
	output wire [3:0]  pulse_width_in,     // Sensed levels on lines 3 to 0.
	output wire        serial2_receive_in, // Serial two receive line.
	output wire        serial3_receive_in  // Serial three receive line.
);

	// Direction registers, cleared by reset, and the pull register, set to all ones by reset.
	reg  [7:0] c_dir_reg;                  // Group C direction.
	reg  [5:0] d_dir_reg;                  // Group D direction.
	reg  [7:0] f_dir_reg;                  // Group F direction.
	reg  [7:0] g_dir_reg;                  // Group G direction.
	reg  [7:0] h_dir_reg;                  // Group H direction.
	reg  [2:0] pull_reg;                   // Resistor enables for F, G and H.
	// Data latches, left alone by reset.
	reg  [5:0] d_data_reg;                 // Group D latch.
	reg  [7:0] f_data_reg;                 // Group F latch.
	reg  [7:0] g_data_reg;                 // Group G latch.
	reg  [7:0] h_data_reg;                 // Group H latch.
	// Captured address phase.
	reg        wr_pend_reg;                // A write data phase follows.
	reg  [6:0] wr_idx_reg;                 // Index of the pending write.
	wire       acc_valid;                  // Address phase taken this edge.
	wire [6:0] acc_idx;                    // Word index of the access.
	reg  [31:0] rd_next;                   // Read data of the address phase.
	wire [7:0] d_read;                     // Group D read value.
	wire [7:0] f_read;                     // Group F read value.
	wire [7:0] g_read;                     // Group G read value.
	wire [7:0] h_read;                     // Group H read value.

	// Zero-wait slave with OKAY only.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign acc_valid = hsel & hready & htrans[`MPPIO_HTRANS_ACT];
	assign acc_idx   = haddr[8:2];

	// Read values: pin level for inputs, latch for outputs.
	assign d_read = {2'b00, (d_dir_reg & d_data_reg) | (~d_dir_reg & group_d_in)};
	assign f_read = (f_dir_reg & f_data_reg) | (~f_dir_reg & group_f_in);
	assign g_read = (g_dir_reg & g_data_reg) | (~g_dir_reg & group_g_in);
	assign h_read = (h_dir_reg & h_data_reg) | (~h_dir_reg & group_h_in);

	// Read decode in the address phase; unmapped addresses read zero.
	always @* begin
		rd_next = 32'h00000000;
		if (acc_idx == `MPPIO_IDX_C_DIR) begin
			rd_next[7:0] = c_dir_reg;
		end else if (acc_idx == `MPPIO_IDX_D_PINS) begin
			rd_next[7:0] = d_read;
		end else if (acc_idx == `MPPIO_IDX_D_DIR) begin
			rd_next[7:0] = {2'b00, d_dir_reg};
		end else if (acc_idx == `MPPIO_IDX_E_PINS) begin
			rd_next[7:0] = group_e_in;
		end else if (acc_idx == `MPPIO_IDX_F_DIR && !expanded_mode) begin
			rd_next[7:0] = f_dir_reg;
		end else if (acc_idx == `MPPIO_IDX_F_PINS && !expanded_mode) begin
			rd_next[7:0] = f_read;
		end else if (acc_idx == `MPPIO_IDX_G_PINS) begin
			rd_next[7:0] = g_read;
		end else if (acc_idx == `MPPIO_IDX_G_DIR) begin
			rd_next[7:0] = g_dir_reg;
		end else if (acc_idx == `MPPIO_IDX_H_PINS) begin
			rd_next[7:0] = h_read;
		end else if (acc_idx == `MPPIO_IDX_H_DIR) begin
			rd_next[7:0] = h_dir_reg;
		end else if (acc_idx == `MPPIO_IDX_PULL) begin
			rd_next[2:0] = pull_reg;
		end
	end

	// Address phase capture and read data register.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 7'h00;
			hrdata      <= 32'h00000000;
		end else begin
			wr_pend_reg <= acc_valid & hwrite;
			if (acc_valid) begin
				wr_idx_reg <= acc_idx;
				if (!hwrite) begin
					hrdata <= rd_next;
				end
			end
		end
	end

	// Control registers written in the data phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			c_dir_reg <= `MPPIO_DIR_RESET;
			d_dir_reg <= 6'h00;
			f_dir_reg <= `MPPIO_DIR_RESET;
			g_dir_reg <= `MPPIO_DIR_RESET;
			h_dir_reg <= `MPPIO_DIR_RESET;
			pull_reg  <= `MPPIO_PULL_RESET;
		end else if (wr_pend_reg) begin
			if (wr_idx_reg == `MPPIO_IDX_C_DIR) begin
				c_dir_reg <= hwdata[7:0];
			end else if (wr_idx_reg == `MPPIO_IDX_D_DIR) begin
				d_dir_reg <= hwdata[5:0];
			end else if (wr_idx_reg == `MPPIO_IDX_F_DIR && !expanded_mode) begin
				f_dir_reg <= hwdata[7:0];
			end else if (wr_idx_reg == `MPPIO_IDX_G_DIR) begin
				g_dir_reg <= hwdata[7:0];
			end else if (wr_idx_reg == `MPPIO_IDX_H_DIR) begin
				h_dir_reg <= hwdata[7:0];
			end else if (wr_idx_reg == `MPPIO_IDX_PULL) begin
				pull_reg  <= hwdata[2:0];
			end
		end
	end

	// Data latches have no reset; writes store, except to group F in expanded mode.
	always @(posedge hclk) begin
		if (wr_pend_reg) begin
			if (wr_idx_reg == `MPPIO_IDX_D_PINS) begin
				d_data_reg <= hwdata[5:0];
			end else if (wr_idx_reg == `MPPIO_IDX_F_PINS && !expanded_mode) begin
				f_data_reg <= hwdata[7:0];
			end else if (wr_idx_reg == `MPPIO_IDX_G_PINS) begin
				g_data_reg <= hwdata[7:0];
			end else if (wr_idx_reg == `MPPIO_IDX_H_PINS) begin
				h_data_reg <= hwdata[7:0];
			end
		end
	end

	// Group C direction goes to the data bus pad logic.
	assign group_c_dir_bit = c_dir_reg;

	// Group D: alternate function overrides latch and direction.
	assign group_d_out = (group_d_alt_en & group_d_alt_out) | (~group_d_alt_en & d_data_reg);
	assign group_d_oe  = (group_d_alt_en & group_d_alt_oe) | (~group_d_alt_en & d_dir_reg);
	assign serial1_receive_in = group_d_in[0];
	assign spi_miso_in        = group_d_in[2];
	assign spi_mosi_in        = group_d_in[3];
	assign spi_sck_in         = group_d_in[4];
	assign spi_ss_in          = group_d_in[5];

	// Group E feeds the converter channel by channel.
	assign analog_channel = group_e_in;

	// Group F: address low byte in expanded mode.
	assign group_f_out    = expanded_mode ? ext_addr_low : f_data_reg;
	assign group_f_oe     = expanded_mode ? 8'hFF : f_dir_reg;
	assign group_f_pullup = (expanded_mode || !pull_reg[`MPPIO_PULL_F]) ? 8'h00 : ~f_dir_reg;

	// Group G: line 7 is the read/write strobe in expanded mode.
	assign group_g_out    = {expanded_mode ? ext_read_write : g_data_reg[7], g_data_reg[6:0]};
	assign group_g_oe     = {expanded_mode | g_dir_reg[7], g_dir_reg[6:0]};
	assign group_g_pullup = pull_reg[`MPPIO_PULL_G] ? ~g_dir_reg[6:0] : 7'h00;

	// Group H: PWM and serial two and three share the lines.
	assign group_h_out = (group_h_alt_en & group_h_alt_out) | (~group_h_alt_en & h_data_reg);
	assign group_h_oe  = (group_h_alt_en & group_h_alt_oe) | (~group_h_alt_en & h_dir_reg);
	assign group_h_pullup   = pull_reg[`MPPIO_PULL_H] ? 4'hF : 4'h0;
	assign group_h_pulldown = pull_reg[`MPPIO_PULL_H] ? 4'hF : 4'h0;
	assign pulse_width_in     = group_h_in[3:0];
	assign serial2_receive_in = group_h_in[4];
	assign serial3_receive_in = group_h_in[6];

endmodule // mppio_port
`default_nettype wire

//--- sim/mppio_checker.sv
// Concurrent checks on the parallel I/O block, seeing only its ports.
// Assumes one hclk domain and a single AHB-Lite slave on the bus.
`timescale 1ns/10ps
`default_nettype none
module mppio_checker (
	input wire logic        hclk, hresetn, hsel, hwrite, hready, expanded_mode,
	input wire logic        ext_read_write, serial1_receive_in, spi_miso_in,
	input wire logic [31:0] haddr, hrdata, hwdata,
	input wire logic [1:0]  htrans,
	input wire logic [5:0]  group_d_oe, group_d_in, group_d_alt_en,
	input wire logic [7:0]  group_e_in, analog_channel, group_f_oe, group_f_out,
	input wire logic [7:0]  ext_addr_low, group_g_oe, group_g_out,
	input wire logic [3:0]  group_h_pullup, group_h_pulldown
);
	logic        wr_q; // A write was taken in the last address phase.
	logic        rd_q; // A read was taken in the last address phase.
	logic [31:0] a_q;  // Address of that phase.
	// Tracks which data phase follows each accepted address phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			a_q  <= 32'h0;
		end else if (hready) begin
			wr_q <= hsel && htrans[1] && hwrite;
			rd_q <= hsel && htrans[1] && !hwrite;
			a_q  <= haddr;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_d_dir_write: assert property (wr_q && a_q == 32'h24 && group_d_alt_en == 6'h00 |=>
		group_d_oe == $past(hwdata[5:0])) else $error("group D enables differ from written direction");
	a_dirs_reset: assert property ($rose(hresetn) && group_d_alt_en == 6'h00 |->
		group_d_oe == 6'h00 && group_g_oe[6:0] == 7'h00) else $error("pins drive right after reset");
	a_d_upper_zero: assert property (rd_q && (a_q == 32'h20 || a_q == 32'h24) |->
		hrdata[31:6] == 26'h0) else $error("group D upper bits not zero");
	a_f_unmapped: assert property (rd_q && expanded_mode && (a_q == 32'h0C || a_q == 32'h14) |->
		hrdata == 32'h0) else $error("group F register visible in expanded mode");
	a_f_addr_out: assert property (expanded_mode |-> group_f_oe == 8'hFF && group_f_out == ext_addr_low)
		else $error("group F does not carry the low address");
	a_g7_strobe: assert property (expanded_mode |-> group_g_oe[7] && group_g_out[7] == ext_read_write)
		else $error("group G line 7 does not carry the strobe");
	a_e_analog: assert property (analog_channel == group_e_in)
		else $error("analog channels differ from group E lines");
	a_d_alt_route: assert property (serial1_receive_in == group_d_in[0] && spi_miso_in == group_d_in[2])
		else $error("group D lines not routed to the peripherals");
	a_h_all_res: assert property (group_h_pullup == group_h_pulldown &&
		(group_h_pullup == 4'h0 || group_h_pullup == 4'hF)) else $error("group H resistors not switched together");
endmodule // mppio_checker
bind mppio_port mppio_checker mppio_checker_i (.*);
`default_nettype wire

//--- sim/mppio_pins.sv
// Model of the circuitry on the block's pins: pulls, drivers and a fixed level.
// Assumes the bench supplies the level that undriven, unpulled lines settle to.
`timescale 1ns/10ps
`default_nettype none
module mppio_pins (
	input wire logic [7:0] ext, group_f_out, group_f_oe, group_f_pullup, group_g_out, group_g_oe,
	input wire logic [5:0] group_d_out, group_d_oe,
	input wire logic [6:0] group_g_pullup,
	input wire logic [7:0] group_h_out, group_h_oe,
	input wire logic [3:0] group_h_pullup, group_h_pulldown,
	output logic [5:0]     group_d_in,
	output logic [7:0]     group_e_in, group_f_in, group_g_in, group_h_in
);
	// A driven line shows the drive; otherwise a pull wins over the outside level.
	assign group_d_in = (group_d_oe & group_d_out) | (~group_d_oe & ext[5:0]);
	assign group_e_in = ext;
	assign group_f_in = (group_f_oe & group_f_out) | (~group_f_oe & (group_f_pullup | ext));
	assign group_g_in = (group_g_oe & group_g_out) | (~group_g_oe & {ext[7], group_g_pullup | ext[6:0]});
	assign group_h_in = (group_h_oe & group_h_out) |
		(~group_h_oe & {group_h_pullup | ext[7:4], ~group_h_pulldown & ext[3:0]});
endmodule // mppio_pins
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the parallel I/O block over AHB-Lite.
// Assumes a zero-wait slave and a pin model settling idle lines to 8'h5A.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, expanded_mode = 0, ext_read_write = 1;
	logic [31:0] haddr = 0, hwdata = 0, q;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [5:0] group_d_alt_en = 0, group_d_alt_out = 0, group_d_alt_oe = 0;
	logic [7:0] ext = 8'h5A, ext_addr_low = 0, group_h_alt_en = 0, group_h_alt_out = 0, group_h_alt_oe = 0;
	int failures = 0, cmp_count = 0, cyc = 0;
	wire [31:0] hrdata;
	wire hready, hreadyout, hresp, serial1_receive_in, spi_miso_in, spi_mosi_in, spi_sck_in, spi_ss_in;
	wire serial2_receive_in, serial3_receive_in;
	wire [5:0] group_d_in, group_d_out, group_d_oe;
	wire [7:0] group_c_dir_bit, group_e_in, analog_channel, group_f_in, group_f_out, group_f_oe, group_f_pullup;
	wire [7:0] group_g_in, group_g_out, group_g_oe, group_h_in, group_h_out, group_h_oe;
	wire [6:0] group_g_pullup;
	wire [3:0] group_h_pullup, group_h_pulldown, pulse_width_in;
	// Write, read-back pairs: address, written word, expected read.
	// No conversion runs in this bench, so the group E read is never in a sample phase.
	logic [31:0] rows [12][3] = '{'{32'h0C, 32'hA5, 32'hA5}, '{32'h14, 32'h00, 32'h5A},
		'{32'h1C, 32'h3C, 32'h3C}, '{32'h24, 32'hFF, 32'h3F}, '{32'h20, 32'h3F, 32'h3F},
		'{32'h1F4, 32'h0F, 32'h0F}, '{32'h1F0, 32'h00, 32'hF0}, '{32'h1FC, 32'h81, 32'h81},
		'{32'h1F8, 32'h00, 32'h7E}, '{32'h28, 32'hFF, 32'h5A}, '{32'h40, 32'hFF, 32'h00},
		'{32'hB0, 32'h03, 32'h03}};
	assign hready = hreadyout; // The one slave's ready is the bus ready.
	mppio_port mppio_port_i (.*);
	mppio_pins mppio_pins_i (.*);
	// Free-running 20 MHz clock.
	initial begin
		forever #25 hclk = ~hclk;
	end
	// Cuts a hang short.
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			print_verdict();
		end
	end
	// One single transfer; each phase is held until ready is seen high.
	task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence: table, then alternate function, expanded mode and a second reset.
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 12; i++) begin
			xfer(1'b1, rows[i][0], rows[i][1], q);
			xfer(1'b0, rows[i][0], 32'h0, q);
			chk(q, rows[i][2]);
		end
		chk({group_c_dir_bit, 2'h0, group_d_oe, 2'h0, group_d_out, group_h_oe}, 32'h3C3F3F0F);
		chk({28'h0, group_h_pulldown}, 32'h0);
		group_d_alt_en <= 6'h01;
		group_d_alt_out <= 6'h01;
		xfer(1'b1, 32'h20, 32'h00, q);
		// The latch takes the write at this very edge, so look once it has settled.
		@(negedge hclk);
		chk({26'h0, group_d_out}, 32'h01);
		expanded_mode <= 1'b1;
		ext_addr_low <= 8'hC3;
		xfer(1'b1, 32'h0C, 32'h00, q);
		xfer(1'b0, 32'h0C, 32'h0, q);
		chk({q[7:0], group_f_out}, 32'h00C3);
		expanded_mode <= 1'b0;
		group_d_alt_en <= 6'h00;
		xfer(1'b0, 32'h0C, 32'h0, q);
		chk(q, 32'hA5);
		// Leave a known value in the group D latch so that a reset can be seen to spare it.
		xfer(1'b1, 32'h20, 32'h15, q);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i]) begin
			xfer(1'b0, rows[i][0], 32'h0, q);
			if (rows[i][0] inside {32'h0C, 32'h1C, 32'h24, 32'h1F4, 32'h1FC}) chk(q, 32'h0);
		end
		chk({26'h0, group_d_out}, 32'h15);
		chk({21'h0, hreadyout, hresp, spi_mosi_in, spi_sck_in, spi_ss_in, serial2_receive_in, serial3_receive_in, pulse_width_in}, 32'h5B0);
		chk({8'h0, group_f_oe, group_f_pullup, 1'b0, group_g_pullup}, 32'h00FF7F);
		print_verdict();
	end
	initial begin
		hresetn = 1'b0;
	end
endmodule // tb
`default_nettype wire
